// ---- common/eipr_pkg.sv ----
// Purpose: Shared constants for the peripheral interrupt priority block.
// Assumes: An 8-bit special function register bus on the system clock.
// Notes: Source indices follow the bit positions of the priority register.
//
// Notes on behaviour
// - Bit 7 sets timer3 priority, 1 high.
// - Bit 6 sets comparator B priority.
// - Bit 5 sets comparator A priority.
// - Bit 4 sets counter array priority.
// - Bit 3 sets ADC conversion-done priority.
// - Bit 2 sets ADC window priority.
// - Bit 1 sets USB function priority.
// - Bit 0 sets SMBus priority.
package eipr_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] EIPR_PRIO_ADDR = 8'hf6;
  localparam logic [7:0] EIPR_PRIO_RESET = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int EIPR_TIMER3_BIT = 7;
  localparam int EIPR_COMP_B_BIT = 6;
  localparam int EIPR_COMP_A_BIT = 5;
  localparam int EIPR_COUNTER_ARRAY_BIT = 4;
  localparam int EIPR_ADC_DONE_BIT = 3;
  localparam int EIPR_ADC_WINDOW_BIT = 2;
  localparam int EIPR_USB_FUNCTION_BIT = 1;
  localparam int EIPR_SMBUS_BIT = 0;
  localparam int EIPR_NUM_SRC = 8;

  // ==========================================================================
  // Service nesting states
  // ==========================================================================
  typedef enum logic [1:0] {
    EIPR_IDLE = 2'b00,
    EIPR_LOW = 2'b01,
    EIPR_HIGH = 2'b10,
    EIPR_BOTH = 2'b11
  } eipr_state_t;

endpackage : eipr_pkg

// ---- common/eipr_pick_if.sv ----
// Purpose: Carries requests and priorities to the picker and its choices back.
// Assumes: Purely combinational exchange within one clock domain.
// Notes: The picker reports the highest-index pending source of each level.
`timescale 1ns/1ns
interface eipr_pick_if;
  logic [7:0] req;
  logic [7:0] prio;
  logic hi_valid;
  logic [2:0] hi_idx;
  logic lo_valid;
  logic [2:0] lo_idx;

  modport ctrl (output req, output prio, input hi_valid, input hi_idx,
                input lo_valid, input lo_idx);
  modport pick (input req, input prio, output hi_valid, output hi_idx,
                output lo_valid, output lo_idx);
endinterface : eipr_pick_if

// ---- rtl/eipr_picker.sv ----
// Purpose: Splits pending requests by priority level and picks one of each.
// Assumes: Requests are already masked of sources in service.
// Notes: Among equal levels the higher bit index wins.
`timescale 1ns/1ns
module eipr_picker (
  eipr_pick_if.pick pk
);

  logic [7:0] hi_req;
  logic [7:0] lo_req;

  // ==========================================================================
  // Level split per source
  // ==========================================================================
  for (genvar g = 0; g < 8; g++) begin : g_split
    assign hi_req[g] = pk.req[g] & pk.prio[g];
    assign lo_req[g] = pk.req[g] & ~pk.prio[g];
  end

  // ==========================================================================
  // Fixed-order encoders
  // ==========================================================================
  always_comb begin
    pk.hi_valid = 1'b0;
    pk.hi_idx = 3'h0;
    pk.lo_valid = 1'b0;
    pk.lo_idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (hi_req[i]) begin
        pk.hi_valid = 1'b1;
        pk.hi_idx = 3'(i);
      end
      if (lo_req[i]) begin
        pk.lo_valid = 1'b1;
        pk.lo_idx = 3'(i);
      end
    end
  end

endmodule : eipr_picker

// ---- rtl/eipr_top.sv ----
// Purpose: Peripheral interrupt priority register and two-level nesting.
// Assumes: Requests and service-done come from logic on clk_sys_i.
// Notes: Register reads return data one cycle after the read strobe.
// A read and a write in the same cycle return the value before the write.
// A source in service is hidden from picking until its routine returns.
// Requests are levels; software clears them at the requesting peripheral.
`timescale 1ns/1ns
module eipr_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Special function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Interrupt requests and service handshake
  input wire logic [7:0] irq_req_i,
  input wire logic svc_done_i,
  // Priority and dispatch outputs
  output logic timer3_prio_o,
  output logic comparator_b_prio_o,
  output logic comparator_a_prio_o,
  output logic counter_array_prio_o,
  output logic adc_done_prio_o,
  output logic adc_window_prio_o,
  output logic usb_function_prio_o,
  output logic smbus_prio_o,
  output logic irq_take_o,
  output logic [2:0] irq_vec_o,
  output logic irq_take_hi_o,
  output logic active_hi_o,
  output logic active_lo_o
);

  eipr_pick_if pk ();

  logic [7:0] peripheral_irq_priority;
  logic [7:0] next_peripheral_irq_priority;
  logic [7:0] next_sfr_rdata;
  eipr_pkg::eipr_state_t state;
  eipr_pkg::eipr_state_t next_state;
  logic [2:0] lo_vec;
  logic [2:0] next_lo_vec;
  logic [2:0] hi_vec;
  logic [2:0] next_hi_vec;
  logic next_irq_take;
  logic [2:0] next_irq_vec;
  logic next_irq_take_hi;
  logic [7:0] in_service;
  logic sel;
  logic lo_held;
  logic hi_held;

  // ==========================================================================
  // Priority register
  // ==========================================================================
  assign sel = (sfr_addr_i == eipr_pkg::EIPR_PRIO_ADDR);

  // Other addresses leave the register alone and read back as zero.
  always_comb begin
    next_peripheral_irq_priority = peripheral_irq_priority;
    next_sfr_rdata = 8'h00;
    if (sfr_wr_i && sel) begin
      next_peripheral_irq_priority = sfr_wdata_i;
    end
    if (sfr_rd_i && sel) begin
      next_sfr_rdata = peripheral_irq_priority;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      peripheral_irq_priority <= eipr_pkg::EIPR_PRIO_RESET;
      sfr_rdata_o <= 8'h00;
    end else begin
      peripheral_irq_priority <= next_peripheral_irq_priority;
      sfr_rdata_o <= next_sfr_rdata;
    end
  end

  // ==========================================================================
  // Per-source priority outputs
  // ==========================================================================
  // Each output has a flip-flop of its own, loaded with the register's next value, so it changes in the same cycle as the register.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      timer3_prio_o <= 1'b0;
      comparator_b_prio_o <= 1'b0;
      comparator_a_prio_o <= 1'b0;
      counter_array_prio_o <= 1'b0;
      adc_done_prio_o <= 1'b0;
      adc_window_prio_o <= 1'b0;
      usb_function_prio_o <= 1'b0;
      smbus_prio_o <= 1'b0;
    end else begin
      timer3_prio_o <= next_peripheral_irq_priority[
        eipr_pkg::EIPR_TIMER3_BIT];
      comparator_b_prio_o <= next_peripheral_irq_priority[
        eipr_pkg::EIPR_COMP_B_BIT];
      comparator_a_prio_o <= next_peripheral_irq_priority[
        eipr_pkg::EIPR_COMP_A_BIT];
      counter_array_prio_o <= next_peripheral_irq_priority[
        eipr_pkg::EIPR_COUNTER_ARRAY_BIT];
      adc_done_prio_o <= next_peripheral_irq_priority[
        eipr_pkg::EIPR_ADC_DONE_BIT];
      adc_window_prio_o <= next_peripheral_irq_priority[
        eipr_pkg::EIPR_ADC_WINDOW_BIT];
      usb_function_prio_o <= next_peripheral_irq_priority[
        eipr_pkg::EIPR_USB_FUNCTION_BIT];
      smbus_prio_o <= next_peripheral_irq_priority[
        eipr_pkg::EIPR_SMBUS_BIT];
    end
  end

  // ==========================================================================
  // Service marking
  // ==========================================================================
  // Sources already in service are hidden so a held request is not retaken.
  // A level holds its source while its routine runs or waits preempted.
  assign lo_held = (state == eipr_pkg::EIPR_LOW) ||
    (state == eipr_pkg::EIPR_BOTH);
  assign hi_held = (state == eipr_pkg::EIPR_HIGH) ||
    (state == eipr_pkg::EIPR_BOTH);

  for (genvar g = 0; g < eipr_pkg::EIPR_NUM_SRC; g++) begin : g_svc
    assign in_service[g] = (lo_held && (lo_vec == 3'(g))) ||
      (hi_held && (hi_vec == 3'(g)));
  end

  // ==========================================================================
  // Request picking
  // ==========================================================================
  assign pk.req = irq_req_i & ~in_service;
  assign pk.prio = peripheral_irq_priority;

  // The picker is combinational; its choices feed the next state.
  eipr_picker u_picker (
    .pk(pk)
  );

  // ==========================================================================
  // Service nesting
  // ==========================================================================
  // Two levels nest at most once: a high request may interrupt a low routine,
  // while nothing interrupts a routine of its own level or above. The state
  // keeps both sources so the low routine resumes when the high one ends.
  always_comb begin
    next_state = state;
    next_lo_vec = lo_vec;
    next_hi_vec = hi_vec;
    next_irq_take = 1'b0;
    next_irq_vec = irq_vec_o;
    next_irq_take_hi = 1'b0;
    unique case (state)
      eipr_pkg::EIPR_IDLE: begin
        // A high request beats any low one pending in the same cycle.
        if (pk.hi_valid) begin
          next_state = eipr_pkg::EIPR_HIGH;
          next_hi_vec = pk.hi_idx;
          next_irq_take = 1'b1;
          next_irq_vec = pk.hi_idx;
          next_irq_take_hi = 1'b1;
        end else if (pk.lo_valid) begin
          next_state = eipr_pkg::EIPR_LOW;
          next_lo_vec = pk.lo_idx;
          next_irq_take = 1'b1;
          next_irq_vec = pk.lo_idx;
        end
      end
      eipr_pkg::EIPR_LOW: begin
        // A return in the same cycle as a high request wins; the request
        // is then taken from idle on the next cycle.
        if (svc_done_i) begin
          next_state = eipr_pkg::EIPR_IDLE;
        end else if (pk.hi_valid) begin
          next_state = eipr_pkg::EIPR_BOTH;
          next_hi_vec = pk.hi_idx;
          next_irq_take = 1'b1;
          next_irq_vec = pk.hi_idx;
          next_irq_take_hi = 1'b1;
        end
      end
      eipr_pkg::EIPR_HIGH: begin
        // Nothing may interrupt a high-level routine.
        if (svc_done_i) begin
          next_state = eipr_pkg::EIPR_IDLE;
        end
      end
      eipr_pkg::EIPR_BOTH: begin
        // Resuming the preempted routine shows its vector without a take.
        if (svc_done_i) begin
          next_state = eipr_pkg::EIPR_LOW;
          next_irq_vec = lo_vec;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= eipr_pkg::EIPR_IDLE;
      lo_vec <= 3'h0;
      hi_vec <= 3'h0;
      irq_take_o <= 1'b0;
      irq_vec_o <= 3'h0;
      irq_take_hi_o <= 1'b0;
      active_hi_o <= 1'b0;
      active_lo_o <= 1'b0;
    end else begin
      state <= next_state;
      lo_vec <= next_lo_vec;
      hi_vec <= next_hi_vec;
      irq_take_o <= next_irq_take;
      irq_vec_o <= next_irq_vec;
      irq_take_hi_o <= next_irq_take_hi;
      // The active flags follow the state, so they move with the take pulse.
      active_hi_o <= next_state[1];
      active_lo_o <= next_state[0];
    end
  end

endmodule : eipr_top

// ---- verification/eipr_asserts.sv ----
// Purpose: Port checks for the peripheral interrupt priority block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to eipr_top; sees only its ports.
`timescale 1ns/1ns
module eipr_asserts (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // Requests and dispatch
  input wire logic [7:0] irq_req_i,
  input wire logic svc_done_i,
  input wire logic timer3_prio_o,
  input wire logic comparator_b_prio_o,
  input wire logic comparator_a_prio_o,
  input wire logic counter_array_prio_o,
  input wire logic adc_done_prio_o,
  input wire logic adc_window_prio_o,
  input wire logic usb_function_prio_o,
  input wire logic smbus_prio_o,
  input wire logic irq_take_o,
  input wire logic [2:0] irq_vec_o,
  input wire logic irq_take_hi_o,
  input wire logic active_hi_o,
  input wire logic active_lo_o
);
  wire logic [7:0] prio;
  wire logic hit;
  wire logic lo_only;
  wire logic [7:0] pend_hi;
  assign prio = {timer3_prio_o, comparator_b_prio_o, comparator_a_prio_o,
    counter_array_prio_o, adc_done_prio_o, adc_window_prio_o,
    usb_function_prio_o, smbus_prio_o};
  assign hit = sfr_addr_i == eipr_pkg::EIPR_PRIO_ADDR;
  assign lo_only = active_lo_o && !active_hi_o && !svc_done_i;
  // The low source in service stays hidden even if made high meanwhile.
  assign pend_hi = irq_req_i & prio & ~(8'h01 << irq_vec_o);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Register checks
  // ==========================================================================
  chk_wr_loads_bits: assert property (sfr_wr_i && hit |=>
    prio == $past(sfr_wdata_i)) else $error("priority write not loaded");
  chk_prio_holds: assert property (!(sfr_wr_i && hit) |=>
    $stable(prio)) else $error("priority changed without write");
  chk_rd_returns: assert property (sfr_rd_i && hit |=>
    sfr_rdata_o == $past(prio)) else $error("read data wrong");
  chk_rd_idle_zero: assert property (!(sfr_rd_i && hit) |=>
    sfr_rdata_o == 8'h00) else $error("read data not zero");
  chk_reset_clears: assert property (disable iff (1'b0)
    rst_i |=> prio == 8'h00 && !irq_take_o) else $error("reset not clear");
  // ==========================================================================
  // Nesting checks
  // ==========================================================================
  chk_hi_preempts: assert property (lo_only && pend_hi != 8'h00
    |=> irq_take_hi_o) else $error("high did not preempt");
  chk_lo_no_nest: assert property (lo_only && pend_hi == 8'h00
    |=> !irq_take_o) else $error("low nested into low");
  chk_hi_no_nest: assert property (active_hi_o |=>
    !irq_take_o) else $error("take while high active");
  chk_take_hi_pair: assert property (irq_take_hi_o |->
    irq_take_o && active_hi_o) else $error("high take unpaired");
endmodule : eipr_asserts
bind eipr_top eipr_asserts u_eipr_asserts (.clk_sys_i, .rst_i, .sfr_addr_i,
  .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .irq_req_i, .svc_done_i,
  .timer3_prio_o, .comparator_b_prio_o, .comparator_a_prio_o,
  .counter_array_prio_o, .adc_done_prio_o, .adc_window_prio_o,
  .usb_function_prio_o, .smbus_prio_o, .irq_take_o, .irq_vec_o,
  .irq_take_hi_o, .active_hi_o, .active_lo_o);

// ---- verification/ext_interrupt_priority_reg_bench.sv ----
// Purpose: Self-checking bench for the interrupt priority block.
// Assumes: Inputs change on the falling edge of the clock.
// Notes: Register reads are sampled one cycle after the strobe.
`timescale 1ns/1ns
module ext_interrupt_priority_reg_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] irq_req_i = 8'h00;
  logic svc_done_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic [7:0] prio;
  logic [2:0] irq_vec_o;
  logic t3, cb, ca, pc, ad, aw, us, sm;
  logic irq_take_o, irq_take_hi_o, active_hi_o, active_lo_o;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  assign prio = {t3, cb, ca, pc, ad, aw, us, sm};
  eipr_top u_eipr_top (.clk_sys_i, .rst_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .irq_req_i, .svc_done_i,
    .timer3_prio_o(t3), .comparator_b_prio_o(cb), .comparator_a_prio_o(ca),
    .counter_array_prio_o(pc), .adc_done_prio_o(ad), .adc_window_prio_o(aw),
    .usb_function_prio_o(us), .smbus_prio_o(sm), .irq_take_o, .irq_vec_o,
    .irq_take_hi_o, .active_hi_o, .active_lo_o);
  always #20 clk_sys_i = ~clk_sys_i;
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic stop_test;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_rd_i = 1'b0;
    chk("read data", e, sfr_rdata_o);
  endtask : reg_rd
  task automatic chk_disp(input logic [7:0] exp_bits);
    @(negedge clk_sys_i);
    chk("dispatch", exp_bits, {irq_take_o, irq_take_hi_o, active_hi_o,
      active_lo_o, 1'b0, irq_vec_o});
  endtask : chk_disp
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk("reset prio", 8'h00, prio);
    reg_rd(8'hf6, 8'h00);
    for (int i = 0; i < 8; i++) begin
      reg_wr(8'hf6, 8'h01 << i);
      chk("prio bits", 8'h01 << i, prio);
      reg_rd(8'hf6, 8'h01 << i);
    end
    reg_wr(8'hf5, 8'hff);
    chk("unmapped write", 8'h80, prio);
    reg_rd(8'hf5, 8'h00);
    @(negedge clk_sys_i);
    sfr_addr_i = 8'hf6;
    sfr_wdata_i = 8'h5a;
    sfr_wr_i = 1'b1;
    sfr_rd_i = 1'b1;
    @(negedge clk_sys_i);
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    chk("read old", 8'h80, sfr_rdata_o);
    chk("new prio", 8'h5a, prio);
    reg_wr(8'hf6, 8'h80);
    irq_req_i = 8'h01;
    chk_disp(8'h90);
    irq_req_i = 8'h81;
    chk_disp(8'hf7);
    irq_req_i = 8'h01;
    svc_done_i = 1'b1;
    chk_disp(8'h10);
    svc_done_i = 1'b0;
    irq_req_i = 8'h03;
    chk_disp(8'h10);
    irq_req_i = 8'h06;
    svc_done_i = 1'b1;
    chk_disp(8'h00);
    svc_done_i = 1'b0;
    chk_disp(8'h92);
    irq_req_i = 8'h80;
    svc_done_i = 1'b1;
    chk_disp(8'h02);
    svc_done_i = 1'b0;
    chk_disp(8'he7);
    irq_req_i = 8'hff;
    chk_disp(8'h27);
    stop_test();
  end
endmodule : ext_interrupt_priority_reg_bench
